// ### wdg_pkg.sv
// constants, types and register map of the standard watchdog block
// assumes a 40 MHz clock and an apb master with 32-bit data
// Contract
// - on every supply-valid rise, classify the timing config pin over 381 us
// - select high: timeout 1600 ms when pin open, 200 ms when pulled up
// - select low: watchdog off, kick input ignored, any config
// - after select re-enables, ignore kick changes for 150 us
// - only a kick falling edge services the timer
// - kicks faster than the timeout keep fault released, else pull it low
// - enable low: watchdog off and kick ignored; high resumes monitoring
// - enable low pulls the mirror low within 200 ns
// - enable low releases the fault output to high impedance
// - enable high with supply valid: release both outputs after 200 ms
// - short enable low gives one reset cycle; held low keeps it off
// - enable input reads high when left open, via internal pull-up
// - fault output and mirror are active-low open-drain drivers
// - kick inactive and mirror held low until supply valid 300 us
// - supply between por and valid: ignore kick, drive mirror low
// - capacitor mode: timeout ms = 77.4 * nF + 55, select high
package wdg_pkg;
  // =====================================================================
  // timing
  localparam int CLK_KHZ       = 40000;
  localparam int EVAL_US       = 381;
  localparam int STARTUP_US    = 300;
  localparam int SETUP_US      = 150;
  localparam int MIRROR_NS     = 200;
  localparam int RST_DELAY_MS  = 200;
  localparam int TWD_OPEN_MS   = 1600;
  localparam int TWD_PULLUP_MS = 200;
  localparam int CAP_SLOPE_X10 = 774;
  localparam int CAP_BASE_MS   = 55;
  localparam int EVAL_CYC      = (EVAL_US * CLK_KHZ + 999) / 1000;
  localparam int STARTUP_CYC   = (STARTUP_US * CLK_KHZ + 999) / 1000;
  localparam int SETUP_CYC     = (SETUP_US * CLK_KHZ + 999) / 1000;
  localparam int MIRROR_CYC    = MIRROR_NS * CLK_KHZ / 1000000;
  localparam int RST_DELAY_CYC = RST_DELAY_MS * CLK_KHZ;
  localparam int TWD_OPEN_CYC  = TWD_OPEN_MS * CLK_KHZ;
  localparam int TWD_PULL_CYC  = TWD_PULLUP_MS * CLK_KHZ;
  localparam int CAP_SLOPE_CYC = CAP_SLOPE_X10 * CLK_KHZ / 10;
  localparam int CAP_BASE_CYC  = CAP_BASE_MS * CLK_KHZ;
  // =====================================================================
  // config pin classes
  localparam logic [1:0] CFG_OPEN   = 2'h0;
  localparam logic [1:0] CFG_PULLUP = 2'h1;
  // =====================================================================
  // register map
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_CAP_NF  = 8'h04;
  localparam logic [7:0] OFF_TIMEOUT = 8'h08;
  localparam logic [9:0] CAP_NF_RST  = 10'h001;
  localparam int ST_STATE  = 0;
  localparam int ST_CFG    = 3;
  localparam int ST_FAULT  = 5;
  localparam int ST_MIRROR = 6;
  localparam int ST_SETUP  = 7;
  localparam int ST_PINS   = 8;
  // =====================================================================
  // input sampling vector
  localparam int IN_KICK   = 0;
  localparam int IN_EN     = 1;
  localparam int IN_SEL    = 2;
  localparam int IN_SUP    = 3;
  localparam int IN_CFG    = 4;
  localparam int IN_FPIN   = 6;
  localparam int IN_MPIN   = 7;
  localparam int IN_W      = 8;
  typedef enum logic [2:0] {
    S_OFF, S_EVAL, S_DISABLED, S_RESET, S_RUN, S_FAULT
  } state_e;
endpackage : wdg_pkg

// ### pin_sync.sv
// two-stage synchroniser for a bundle of pin levels
// assumes the levels are slow against the clock
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK_I,
  input  wire logic         RST_N_I,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  // first stage feeds the second only
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ### standard_watchdog_with_enable.sv
// standard watchdog with enable input, mirror and apb status port
// assumes pads resolve open-drain wires and the enable pull-up
`timescale 1ns/10ps
`default_nettype none
module standard_watchdog_with_enable
  import wdg_pkg::*;
#(
  parameter logic [31:0] EVAL_CYCLES    = 32'(EVAL_CYC),
  parameter logic [31:0] STARTUP_CYCLES = 32'(STARTUP_CYC),
  parameter logic [31:0] SETUP_CYCLES   = 32'(SETUP_CYC),
  parameter logic [31:0] RST_CYCLES     = 32'(RST_DELAY_CYC),
  parameter logic [31:0] TWD_OPEN       = 32'(TWD_OPEN_CYC),
  parameter logic [31:0] TWD_PULLUP     = 32'(TWD_PULL_CYC),
  parameter logic [31:0] CAP_SLOPE      = 32'(CAP_SLOPE_CYC),
  parameter logic [31:0] CAP_BASE       = 32'(CAP_BASE_CYC)
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        SUPPLY_VALID_I,
  input  wire logic        KICK_INPUT_I,
  input  wire logic        ENABLE_I,
  input  wire logic        TIMEOUT_ENABLE_SELECT_I,
  input  wire logic [1:0]  TIMING_CONFIG_PIN_I,
  input  wire logic        FAULT_OUTPUT_N_I,
  output logic             FAULT_OUTPUT_N_O,
  output logic             FAULT_OUTPUT_N_OE_O,
  input  wire logic        ENABLE_OUTPUT_MIRROR_I,
  output logic             ENABLE_OUTPUT_MIRROR_O,
  output logic             ENABLE_OUTPUT_MIRROR_OE_O
);
  // =====================================================================
  // state
  typedef struct packed {
    state_e      st;
    logic [31:0] cnt;
    logic [31:0] wd_cnt;
    logic [31:0] su_cnt;
    logic        su_busy;
    logic        sel_q;
    logic        kick_q;
    logic [1:0]  cfg;
    logic [9:0]  cap_nf;
    logic        fault_oe;
    logic        mirror_oe;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_s;

  localparam state_s RST_S = '{st: S_OFF, cap_nf: CAP_NF_RST, default: '0};

  state_s           s;
  state_s           next_s;
  logic [IN_W-1:0]  pins;
  logic             kick;
  logic             en;
  logic             sel;
  logic             sup;
  logic             kick_fall;
  logic [31:0]      tmo;
  logic             apb_acc;

  // =====================================================================
  // pin sampling
  pin_sync #(.W(IN_W)) u_sync (
    .CLK_I   (CLK_I),
    .RST_N_I (RST_N_I),
    .d_i     ({ENABLE_OUTPUT_MIRROR_I, FAULT_OUTPUT_N_I,
               TIMING_CONFIG_PIN_I, SUPPLY_VALID_I,
               TIMEOUT_ENABLE_SELECT_I, ENABLE_I, KICK_INPUT_I}),
    .q_o     (pins)
  );

  assign kick = pins[IN_KICK];
  // open enable pin reads high through the pad pull-up
  assign en   = pins[IN_EN];
  assign sel  = pins[IN_SEL];
  assign sup  = pins[IN_SUP];
  // falling edge only; rises and levels are not service events
  assign kick_fall = s.kick_q & ~kick;
  assign apb_acc   = PSEL_I & PENABLE_I;

  // =====================================================================
  // timeout selection
  always_comb begin
    if (s.cfg == CFG_OPEN) begin
      tmo = TWD_OPEN;
    end else if (s.cfg == CFG_PULLUP) begin
      tmo = TWD_PULLUP;
    end else begin
      // fits 32 bits up to the full 10-bit capacitance range
      tmo = CAP_SLOPE * s.cap_nf + CAP_BASE;
    end
  end

  function automatic logic [32:0] reg_read(input logic [7:0] a,
                                           input state_s  q,
                                           input logic [IN_W-1:0] p,
                                           input logic [31:0] t);
    logic [31:0] d;
    d = '0;
    case (a)
      OFF_STATUS: begin
        d[ST_STATE+:3] = q.st;
        d[ST_CFG+:2]   = q.cfg;
        d[ST_FAULT]    = q.fault_oe;
        d[ST_MIRROR]   = q.mirror_oe;
        d[ST_SETUP]    = q.su_busy;
        d[ST_PINS+:IN_W] = p;
        reg_read = {1'b0, d};
      end
      OFF_CAP_NF:  reg_read = {1'b0, 22'h0, q.cap_nf};
      OFF_TIMEOUT: reg_read = {1'b0, t};
      default:     reg_read = {1'b1, 32'h0};
    endcase
  endfunction : reg_read

  // =====================================================================
  // next state
  always_comb begin
    next_s        = s;
    next_s.kick_q = kick;
    next_s.sel_q  = sel;
    // apb: one wait state, read data captured from current state
    next_s.pready = 1'b0;
    if (apb_acc && !s.pready) begin
      next_s.pready = 1'b1;
      {next_s.pslverr, next_s.prdata} = reg_read(PADDR_I, s, pins, tmo);
      if (PADDR_I[1:0] != 2'h0) begin
        next_s.pslverr = 1'b1;
      end
    end
    if (apb_acc && s.pready && PWRITE_I && PADDR_I == OFF_CAP_NF) begin
      next_s.cap_nf = PWDATA_I[9:0];
    end

    if (!sup) begin
      // below valid supply: kick ignored, both pulled low
      next_s.st        = S_OFF;
      next_s.mirror_oe = 1'b1;
      next_s.fault_oe  = 1'b1;
      next_s.cnt       = '0;
    end else begin
      case (s.st)
        S_OFF: begin
          next_s.st  = S_EVAL;
          next_s.cnt = '0;
        end
        S_EVAL: begin
          // eval outlasts startup, so it also covers the 300 us hold
          next_s.cnt = s.cnt + 32'h1;
          next_s.cfg = pins[IN_CFG+:2];
          if (s.cnt >= EVAL_CYCLES - 32'h1 &&
              s.cnt >= STARTUP_CYCLES - 32'h1) begin
            next_s.cnt = '0;
            next_s.st  = en ? S_RESET : S_DISABLED;
            // entering disabled straight from eval must release the fault
            next_s.fault_oe = en;
          end
        end
        S_DISABLED: begin
          next_s.mirror_oe = 1'b1;
          next_s.fault_oe  = 1'b0;
          next_s.cnt       = '0;
          if (en) begin
            next_s.st       = S_RESET;
            next_s.fault_oe = 1'b1;
          end
        end
        S_RESET: begin
          next_s.mirror_oe = 1'b1;
          next_s.fault_oe  = 1'b1;
          next_s.cnt       = s.cnt + 32'h1;
          if (!en) begin
            next_s.st       = S_DISABLED;
            next_s.fault_oe = 1'b0;
          end else if (s.cnt >= RST_CYCLES - 32'h1) begin
            next_s.st        = S_RUN;
            next_s.mirror_oe = 1'b0;
            next_s.fault_oe  = 1'b0;
            next_s.wd_cnt    = '0;
            next_s.su_busy   = 1'b0;
          end
        end
        S_RUN: begin
          if (!en) begin
            next_s.st        = S_DISABLED;
            next_s.mirror_oe = 1'b1;
            next_s.fault_oe  = 1'b0;
          end else if (!sel) begin
            // watchdog off, kick ignored
            next_s.su_busy = 1'b0;
            next_s.wd_cnt  = '0;
          end else if (!s.sel_q || s.su_busy) begin
            // re-enable: kick changes ignored during setup
            next_s.su_busy = 1'b1;
            next_s.su_cnt  = s.su_busy ? s.su_cnt + 32'h1 : '0;
            if (s.su_busy && s.su_cnt >= SETUP_CYCLES - 32'h1) begin
              next_s.su_busy = 1'b0;
              next_s.wd_cnt  = '0;
            end
          end else if (kick_fall) begin
            next_s.wd_cnt = '0;
          end else if (s.wd_cnt >= tmo - 32'h1) begin
            next_s.st       = S_FAULT;
            next_s.fault_oe = 1'b1;
            next_s.cnt      = '0;
          end else begin
            next_s.wd_cnt = s.wd_cnt + 32'h1;
          end
        end
        S_FAULT: begin
          // fault held for one reset delay, or until select goes low, then monitoring restarts
          next_s.cnt = s.cnt + 32'h1;
          if (!en) begin
            next_s.st        = S_DISABLED;
            next_s.mirror_oe = 1'b1;
            next_s.fault_oe  = 1'b0;
          end else if (!sel || s.cnt >= RST_CYCLES - 32'h1) begin
            next_s.st       = S_RUN;
            next_s.fault_oe = 1'b0;
            next_s.wd_cnt   = '0;
          end
        end
        default: begin
          next_s.st = S_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  // =====================================================================
  // outputs: apb from registers; pins open drain, value always low, enable means pull down
  assign PRDATA_O                  = s.prdata;
  assign PREADY_O                  = s.pready;
  assign PSLVERR_O                 = s.pslverr;
  assign FAULT_OUTPUT_N_O          = 1'b0;
  assign FAULT_OUTPUT_N_OE_O       = s.fault_oe;
  assign ENABLE_OUTPUT_MIRROR_O    = 1'b0;
  assign ENABLE_OUTPUT_MIRROR_OE_O = s.mirror_oe;

  // =====================================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  chk_eval_length: assert property (
    $past(s.st) == S_EVAL && s.st != S_EVAL && $past(sup)
      |-> $past(s.cnt) == EVAL_CYCLES - 32'h1)
    else $error("config evaluation ended at wrong count");

  chk_timeout_expiry: assert property (
    s.st == S_RUN && en && sel && s.sel_q && !s.su_busy && !kick_fall
      && s.wd_cnt == tmo - 32'h1 && sup |=> s.st == S_FAULT && s.fault_oe)
    else $error("timeout expiry did not raise fault");

  chk_sel_off_quiet: assert property (
    s.st == S_RUN && !s.sel_q |-> !s.fault_oe && s.wd_cnt == 32'h0)
    else $error("watchdog active while select low");

  chk_setup_hold: assert property (
    s.su_busy && $past(s.su_busy) |-> s.wd_cnt == $past(s.wd_cnt))
    else $error("kick counter moved during setup");

  chk_kick_fall: assert property (
    s.st == S_RUN && en && sel && s.sel_q && !s.su_busy && kick_fall
      && sup |=> s.wd_cnt == 32'h0 && s.st == S_RUN)
    else $error("kick falling edge did not restart counter");

  chk_mirror_fast: assert property (
    $fell(ENABLE_I) && s.st != S_OFF |-> ##[1:3] s.mirror_oe)
    else $error("mirror not pulled low in time");

  chk_fault_release: assert property (
    s.st == S_DISABLED |-> !s.fault_oe && s.mirror_oe)
    else $error("fault driven while enable low");

  chk_reset_delay: assert property (
    $past(s.st) == S_RESET && s.st == S_RUN
      |-> $past(s.cnt) == RST_CYCLES - 32'h1 && !s.mirror_oe)
    else $error("release after wrong reset delay");

  chk_supply_low: assert property (
    !sup |=> s.mirror_oe && s.st == S_OFF)
    else $error("mirror released with supply invalid");

  cov_fault:   cover property (s.st == S_RUN ##1 s.st == S_FAULT);
  cov_pulse:   cover property (s.st == S_DISABLED ##1 s.st == S_RESET);
  cov_setup:   cover property (s.su_busy ##1 !s.su_busy && s.st == S_RUN);
  cov_capmode: cover property (s.st == S_RUN && s.cfg[1]);
endmodule : standard_watchdog_with_enable
`default_nettype wire

// ### wdg_host.sv
// host model that services the watchdog with periodic kick pulses
// assumes the bench clock and a run level from the bench
`timescale 1ns/10ps
`default_nettype none
module wdg_host (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] period_i,
  output logic            kick_o
);
  logic [7:0] cnt;
  initial cnt = 8'h00;
  initial kick_o = 1'b1;
  // =====================================================================
  // kick pulses: low for four clocks, well above the 50 ns minimum
  always @(posedge clk_i) begin
    cnt <= (cnt >= period_i) ? 8'h00 : cnt + 8'h01;
    kick_o <= !(run_i && cnt < 8'h04);
  end
endmodule : wdg_host
`default_nettype wire

// ### standard_watchdog_with_enable_tb.sv
// self-checking bench for the standard watchdog block
// assumes short counts set by parameters and pull-ups on both wires
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module standard_watchdog_with_enable_tb;
  import wdg_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, sup = 1'b0, en = 1'b1, sel = 1'b1, run = 1'b0;
  logic [7:0]  paddr = 8'h00, period = 8'h32;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [1:0]  cfg = 2'h0;
  logic        prdy, perr, err, kick, f_o, f_oe, m_o, m_oe, f_w, m_w;
  int          failures = 0, n_checks = 0, i;
  always #12.5 clk = ~clk;
  // open-drain wires with external pull-ups
  assign f_w = f_oe ? f_o : 1'b1;
  assign m_w = m_oe ? m_o : 1'b1;
  wdg_host i_wdg_host (.clk_i(clk), .run_i(run), .period_i(period),
    .kick_o(kick));
  // eval, startup and setup run at their true lengths
  standard_watchdog_with_enable #(.RST_CYCLES(32'd50),
    .TWD_OPEN(32'd200), .TWD_PULLUP(32'd100), .CAP_SLOPE(32'd10),
    .CAP_BASE(32'd20)) i_standard_watchdog_with_enable (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .SUPPLY_VALID_I(sup),
    .KICK_INPUT_I(kick), .ENABLE_I(en), .TIMEOUT_ENABLE_SELECT_I(sel),
    .TIMING_CONFIG_PIN_I(cfg), .FAULT_OUTPUT_N_I(f_w),
    .FAULT_OUTPUT_N_O(f_o), .FAULT_OUTPUT_N_OE_O(f_oe),
    .ENABLE_OUTPUT_MIRROR_I(m_w), .ENABLE_OUTPUT_MIRROR_O(m_o),
    .ENABLE_OUTPUT_MIRROR_OE_O(m_oe));
  // =====================================================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // no cycle count assumed; only the bench timeout ends this wait
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    rd = prd;
    err = perr;
    psel <= 1'b0; pen <= 1'b0;
    // idle edge so a following call never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // =====================================================================
  // watchdog on the run itself
  initial begin
    #(25 * 80000);
    failures++;
    print_verdict();
  end
  // =====================================================================
  // scenarios
  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(1);
    `CHK({f_oe, m_oe, f_o, m_o}, 4'h0)
    apb(1'b0, OFF_CAP_NF, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(err, 1'b1)
    sup <= 1'b1; run <= 1'b1;
    cyc(20);
    `CHK(m_w, 1'b0)
    cyc(EVAL_CYC + 90);
    `CHK({f_w, m_w}, 2'h3)
    apb(1'b0, OFF_TIMEOUT, 32'h0);
    `CHK(rd, 32'd200)
    i = 0;
    repeat (600) begin
      @(posedge clk);
      if (f_w !== 1'b1) i++;
    end
    `CHK(i, 0)
    run <= 1'b0;
    cyc(150);
    `CHK(f_w, 1'b1)
    i = 0;
    while (f_w !== 1'b0 && i < 150) begin
      i++;
      @(posedge clk);
    end
    `CHK(f_w, 1'b0)
    run <= 1'b1;
    cyc(70);
    `CHK(f_w, 1'b1)
    en <= 1'b0; run <= 1'b0;
    cyc(8);
    `CHK({m_w, f_w, f_oe}, 3'h2)
    cyc(300);
    `CHK(f_w, 1'b1)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h2)
    en <= 1'b1; run <= 1'b1;
    cyc(20);
    `CHK({f_w, m_w}, 2'h0)
    cyc(60);
    `CHK({f_w, m_w}, 2'h3)
    // select kept low for a long disable
    sel <= 1'b0; run <= 1'b0;
    cyc(300);
    `CHK(f_w, 1'b1)
    sel <= 1'b1;
    cyc(15);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[ST_SETUP], 1'b1)
    // setup runs its full length; the count starts only at its end
    cyc(SETUP_CYC);
    `CHK(f_w, 1'b1)
    cyc(190);
    `CHK(f_w, 1'b0)
    run <= 1'b1;
    // slower kicks, still inside the shorter timeouts below
    period <= 8'h3c;
    // pulled-up and capacitor classes on a fresh supply rise
    for (int c = 1; c < 3; c++) begin
      sup <= 1'b0;
      cfg <= 2'(c);
      cyc(10);
      apb(1'b1, OFF_CAP_NF, 32'h5);
      sup <= 1'b1;
      cyc(EVAL_CYC + 110);
      `CHK({f_w, m_w}, 2'h3)
      apb(1'b0, OFF_CAP_NF, 32'h0);
      `CHK(rd, 32'h5)
      apb(1'b0, OFF_TIMEOUT, 32'h0);
      `CHK(rd, (c == 1) ? 32'd100 : 32'd70)
    end
    print_verdict();
  end
endmodule : standard_watchdog_with_enable_tb
`undef CHK
`default_nettype wire
